/* File: rtl/cbt_pkg.sv */
// constants and types of the bit, transfer and core-control executor
// assumes one clock; memories and i/o space sit outside the core
// How it works
// - io bit set forces one addressed i/o bit high, flags kept, 2 cycles
// - io bit clear forces one addressed i/o bit low, flags kept, 2 cycles
// - single-bit i/o set and clear reach only i/o addresses 0x00 to 0x1F
// - shift left logical: bits move up, bit 0 gets zero, Z C N V, 1 cycle
// - shift right logical: bits move down, bit 7 gets zero, Z C N V, 1 cycle
// - rotate left through carry: old carry to bit 0, bit 7 to carry, 1 cycle
// - rotate right through carry: old carry to bit 7, bit 0 to carry, 1 cycle
// - signed shift right keeps the sign bit, updates Z C N V, 1 cycle
// - nibble exchange swaps register halves in 1 cycle, no flag touched
// - one-cycle set or clear of one chosen status flag, others untouched
// - chosen register bit copied into the transfer flag in 1 cycle
// - transfer flag copied into chosen register bit, flags kept, 1 cycle
// - post-increment load reads at pointer then adds one, 2 cycles
// - pre-decrement load subtracts one first then reads, 2 cycles
// - offset load reads at pointer plus displacement, pointer kept, 2 cycles
// - pointer writes mirror the load forms, 2 cycles, flags kept
// - direct load and write use the address in the instruction, 2 cycles
// - data addresses of i/o registers are the i/o address plus 0x20
// - program memory read at third pointer, 3 cycles, optional increment
// - stack save writes a register onto the stack in 2 cycles
// - stack restore loads a register from the stack in 2 cycles
// - watchdog restart takes 1 cycle, keeps flags, signals the watchdog
// - debug halt serves only the debug facility, no fixed cycle count
package cbt_pkg;
  localparam int NUM_WREG = 32;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  localparam logic [15:0] IO_DATA_OFFSET = 16'h0020;
  localparam logic [15:0] IO_DATA_END = 16'h0060;
  localparam logic [5:0] IO_BIT_LAST = 6'h1F;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] SP_RESET_DEFAULT = 16'h00FF;
  // status flag positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;
  // register port map: 0x00..0x1F are the working registers
  localparam logic [5:0] BUS_FLAGS_ADDR = 6'h20;
  localparam logic [5:0] BUS_SP_LO_ADDR = 6'h21;
  localparam logic [5:0] BUS_SP_HI_ADDR = 6'h22;

  typedef enum logic [4:0] {
    OP_NOP, OP_IO_SET, OP_IO_CLR, OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROT_LEFT,
    OP_ROT_RIGHT, OP_SHIFT_SIGNED, OP_NIBBLE_SWAP, OP_FLAG_HIGH, OP_FLAG_LOW,
    OP_BIT_TO_T, OP_T_TO_BIT, OP_LOAD, OP_LOAD_INC, OP_LOAD_DEC, OP_LOAD_OFS,
    OP_STORE, OP_STORE_INC, OP_STORE_DEC, OP_STORE_OFS, OP_LOAD_DIRECT,
    OP_STORE_DIRECT, OP_PROG_READ, OP_PROG_READ_INC, OP_PUSH, OP_POP,
    OP_WDOG_KICK, OP_DEBUG_HALT
  } cbt_op_type;

  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} cbt_ptr_type;

  typedef struct packed {
    cbt_op_type op;
    logic [4:0] reg_sel;
    logic [2:0] bit_sel;
    cbt_ptr_type ptr;
    logic [5:0] disp;
    logic [15:0] addr;
    logic [4:0] io_addr;
  } cbt_cmd_type;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cbt_mem_req_type;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [5:0] addr;
    logic [7:0] wdata;
  } cbt_io_req_type;
endpackage

/* File: rtl/cbt_core.sv */
// executor for bit, data-transfer and core-control operations
// assumes data memory and i/o space answer reads in the strobe cycle,
// program memory one cycle after its strobe
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module cbt_core
  import cbt_pkg::*;
#(
  parameter logic [15:0] SP_RESET = SP_RESET_DEFAULT
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // instruction stream
  input wire logic cmd_valid_in,
  input wire cbt_cmd_type cmd_in,
  output logic cmd_ready_out,
  // data memory
  output cbt_mem_req_type dm_req_out,
  input wire logic [7:0] dm_rdata_in,
  // i/o register space
  output cbt_io_req_type io_req_out,
  input wire logic [7:0] io_rdata_in,
  // program memory
  output logic pm_rd_out,
  output logic [15:0] pm_addr_out,
  input wire logic [7:0] pm_rdata_in,
  // core control
  output logic wdog_kick_out,
  output logic dbg_halted_out,
  input wire logic dbg_resume_in,
  output logic [7:0] flags_out,
  // register port
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out
);

  typedef enum logic [2:0] {S_IDLE, S_DATA, S_IO_RD, S_PM_WAIT, S_PM_CAP, S_HALT} cbt_state_type;

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction

  function automatic logic [4:0] ptr_base(input cbt_ptr_type p);
    case (p)
      PTR_X: ptr_base = PTR_X_LO;
      PTR_Y: ptr_base = PTR_Y_LO;
      default: ptr_base = PTR_Z_LO;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  cbt_state_type state_ff, nxt_state;
  logic ready_ff, nxt_ready;
  logic [7:0] wreg_ff [NUM_WREG];
  logic [7:0] nxt_wreg [NUM_WREG];
  logic [7:0] flags_ff, nxt_flags;
  logic [15:0] sp_ff, nxt_sp;
  logic [4:0] pend_reg_ff;
  logic pend_load_ff, pend_io_ff, pend_set_ff;
  logic [2:0] pend_bit_ff;
  cbt_mem_req_type dm_req_ff, nxt_dm_req;
  cbt_io_req_type io_req_ff, nxt_io_req;
  logic pm_rd_ff;
  logic [15:0] pm_addr_ff;
  logic wdog_ff, halted_ff, nxt_halted;
  logic [7:0] reg_rdata_ff, nxt_reg_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // operand decode
  wire logic accept = cmd_valid_in & ready_ff;
  wire cbt_op_type op = cmd_in.op;
  wire logic [7:0] rd_val = wreg_ff[cmd_in.reg_sel];
  wire logic [7:0] sel_mask = bit_mask(cmd_in.bit_sel);
  wire logic is_prog = (op == OP_PROG_READ) || (op == OP_PROG_READ_INC);
  wire logic [4:0] ptr_lo_idx = is_prog ? PTR_Z_LO : ptr_base(cmd_in.ptr);
  wire logic [4:0] ptr_hi_idx = ptr_lo_idx | 5'h01;
  wire logic [15:0] ptr_val = {wreg_ff[ptr_hi_idx], wreg_ff[ptr_lo_idx]};
  wire logic [15:0] ptr_inc = ptr_val + PTR_STEP;
  wire logic [15:0] ptr_dec = ptr_val - PTR_STEP;
  wire logic [15:0] ptr_ofs = ptr_val + {10'h000, cmd_in.disp};
  wire logic [15:0] sp_inc = sp_ff + PTR_STEP;
  wire logic [15:0] sp_dec = sp_ff - PTR_STEP;

  logic is_load, is_store, is_shift, ptr_up, ptr_down;
  logic [15:0] data_addr;
  logic [7:0] sh_res;
  logic sh_c;

  always_comb
  begin
    is_load = 1'b0;
    is_store = 1'b0;
    ptr_up = 1'b0;
    ptr_down = 1'b0;
    data_addr = ptr_val;
    case (op)
      OP_LOAD: is_load = 1'b1;
      OP_LOAD_INC:
      begin
        is_load = 1'b1;
        ptr_up = 1'b1;
      end
      OP_LOAD_DEC:
      begin
        is_load = 1'b1;
        ptr_down = 1'b1;
        data_addr = ptr_dec;
      end
      OP_LOAD_OFS:
      begin
        is_load = 1'b1;
        data_addr = ptr_ofs;
      end
      OP_STORE: is_store = 1'b1;
      OP_STORE_INC:
      begin
        is_store = 1'b1;
        ptr_up = 1'b1;
      end
      OP_STORE_DEC:
      begin
        is_store = 1'b1;
        ptr_down = 1'b1;
        data_addr = ptr_dec;
      end
      OP_STORE_OFS:
      begin
        is_store = 1'b1;
        data_addr = ptr_ofs;
      end
      OP_LOAD_DIRECT:
      begin
        is_load = 1'b1;
        data_addr = cmd_in.addr;
      end
      OP_STORE_DIRECT:
      begin
        is_store = 1'b1;
        data_addr = cmd_in.addr;
      end
      OP_PUSH:
      begin
        is_store = 1'b1;
        data_addr = sp_ff;
      end
      OP_POP:
      begin
        is_load = 1'b1;
        data_addr = sp_inc;
      end
      OP_PROG_READ_INC: ptr_up = 1'b1;
      default: ptr_up = 1'b0;
    endcase
  end

  wire logic data_is_io = (data_addr >= IO_DATA_OFFSET) && (data_addr < IO_DATA_END);
  wire logic [15:0] io_from_data = data_addr - IO_DATA_OFFSET;

  ////////////////////////////////////////////////////////////////////////////
  // single-cycle shifter
  always_comb
  begin
    is_shift = 1'b1;
    sh_res = rd_val;
    sh_c = rd_val[0];
    case (op)
      OP_SHIFT_LEFT:
      begin
        sh_res = {rd_val[6:0], 1'b0};
        sh_c = rd_val[7];
      end
      OP_SHIFT_RIGHT: sh_res = {1'b0, rd_val[7:1]};
      OP_ROT_LEFT:
      begin
        sh_res = {rd_val[6:0], flags_ff[FLAG_C]};
        sh_c = rd_val[7];
      end
      OP_ROT_RIGHT: sh_res = {flags_ff[FLAG_C], rd_val[7:1]};
      OP_SHIFT_SIGNED: sh_res = {rd_val[7], rd_val[7:1]};
      default: is_shift = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags
  always_comb
  begin
    nxt_flags = flags_ff;
    if (accept && is_shift)
    begin
      nxt_flags[FLAG_C] = sh_c;
      nxt_flags[FLAG_Z] = (sh_res == BYTE_ZERO);
      nxt_flags[FLAG_N] = sh_res[7];
      nxt_flags[FLAG_V] = sh_res[7] ^ sh_c;
    end
    else if (accept && op == OP_FLAG_HIGH)
      nxt_flags = flags_ff | sel_mask;
    else if (accept && op == OP_FLAG_LOW)
      nxt_flags = flags_ff & ~sel_mask;
    else if (accept && op == OP_BIT_TO_T)
      nxt_flags[FLAG_T] = rd_val[cmd_in.bit_sel];
    else if (reg_wr_in && reg_addr_in == BUS_FLAGS_ADDR)
      nxt_flags = reg_wdata_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // working register writes
  wire logic load_done = (state_ff == S_DATA) && pend_load_ff;
  wire logic prog_done = (state_ff == S_PM_CAP);
  wire logic [7:0] load_data = pend_io_ff ? io_rdata_in : dm_rdata_in;
  wire logic [7:0] t_merged = flags_ff[FLAG_T] ? (rd_val | sel_mask) : (rd_val & ~sel_mask);
  wire logic acc_wr = accept && (is_shift || op == OP_NIBBLE_SWAP || op == OP_T_TO_BIT);
  wire logic [7:0] acc_data = (op == OP_NIBBLE_SWAP) ? {rd_val[3:0], rd_val[7:4]}
                            : (op == OP_T_TO_BIT) ? t_merged : sh_res;
  wire logic ex_wr = acc_wr || load_done || prog_done;
  wire logic [4:0] ex_idx = acc_wr ? cmd_in.reg_sel : pend_reg_ff;
  wire logic [7:0] ex_data = acc_wr ? acc_data : (prog_done ? pm_rdata_in : load_data);
  wire logic ptr_wr = accept && (ptr_up || ptr_down);
  wire logic [15:0] ptr_new = ptr_up ? ptr_inc : ptr_dec;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WREG; gi++)
    begin : g_wreg
      // core writes win over the register port in the same cycle
      assign nxt_wreg[gi] = (ex_wr && ex_idx == 5'(gi)) ? ex_data
                          : (ptr_wr && ptr_lo_idx == 5'(gi)) ? ptr_new[7:0]
                          : (ptr_wr && ptr_hi_idx == 5'(gi)) ? ptr_new[15:8]
                          : (reg_wr_in && reg_addr_in == 6'(gi)) ? reg_wdata_in
                          : wreg_ff[gi];
      always_ff @(posedge mclk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
          wreg_ff[gi] <= BYTE_ZERO;
        else
          wreg_ff[gi] <= nxt_wreg[gi];
      end
    end
  endgenerate

  assign nxt_sp = (accept && op == OP_PUSH) ? sp_dec
                : (accept && op == OP_POP) ? sp_inc
                : (reg_wr_in && reg_addr_in == BUS_SP_LO_ADDR) ? {sp_ff[15:8], reg_wdata_in}
                : (reg_wr_in && reg_addr_in == BUS_SP_HI_ADDR) ? {reg_wdata_in, sp_ff[7:0]}
                : sp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  wire logic mem_op = is_load || is_store;
  wire logic io_bit_op = (op == OP_IO_SET) || (op == OP_IO_CLR);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:
        if (accept)
        begin
          if (io_bit_op)
            nxt_state = S_IO_RD;
          else if (mem_op)
            nxt_state = S_DATA;
          else if (is_prog)
            nxt_state = S_PM_WAIT;
          else if (op == OP_DEBUG_HALT)
            nxt_state = S_HALT;
        end
      S_DATA: nxt_state = S_IDLE;
      S_IO_RD: nxt_state = S_IDLE;
      S_PM_WAIT: nxt_state = S_PM_CAP;
      S_PM_CAP: nxt_state = S_IDLE;
      S_HALT:
        if (dbg_resume_in)
          nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  assign nxt_ready = (nxt_state == S_IDLE);
  assign nxt_halted = (nxt_state == S_HALT);

  ////////////////////////////////////////////////////////////////////////////
  // memory and i/o requests
  wire logic [7:0] io_modified = pend_set_ff ? (io_rdata_in | bit_mask(pend_bit_ff))
                                             : (io_rdata_in & ~bit_mask(pend_bit_ff));

  always_comb
  begin
    nxt_dm_req = '0;
    nxt_io_req = '0;
    // five-bit field keeps bit ops below 0x20
    if (accept && io_bit_op)
    begin
      nxt_io_req.rd_en = 1'b1;
      nxt_io_req.addr = {1'b0, cmd_in.io_addr};
    end
    else if (accept && mem_op && data_is_io)
    begin
      nxt_io_req.rd_en = is_load;
      nxt_io_req.wr_en = is_store;
      nxt_io_req.addr = io_from_data[5:0];
      nxt_io_req.wdata = rd_val;
    end
    else if (accept && mem_op)
    begin
      nxt_dm_req.rd_en = is_load;
      nxt_dm_req.wr_en = is_store;
      nxt_dm_req.addr = data_addr;
      nxt_dm_req.wdata = rd_val;
    end
    else if (state_ff == S_IO_RD)
    begin
      nxt_io_req.wr_en = 1'b1;
      nxt_io_req.addr = io_req_ff.addr;
      nxt_io_req.wdata = io_modified;
    end
  end

  assign nxt_reg_rdata = !reg_rd_in ? BYTE_ZERO
                       : (reg_addr_in < 6'h20) ? wreg_ff[reg_addr_in[4:0]]
                       : (reg_addr_in == BUS_FLAGS_ADDR) ? flags_ff
                       : (reg_addr_in == BUS_SP_LO_ADDR) ? sp_ff[7:0]
                       : (reg_addr_in == BUS_SP_HI_ADDR) ? sp_ff[15:8]
                       : BYTE_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_ff <= S_IDLE;
      ready_ff <= 1'b1;
      flags_ff <= FLAGS_RESET;
      sp_ff <= SP_RESET;
      halted_ff <= 1'b0;
      reg_rdata_ff <= BYTE_ZERO;
    end
    else
    begin
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
      flags_ff <= nxt_flags;
      sp_ff <= nxt_sp;
      halted_ff <= nxt_halted;
      reg_rdata_ff <= nxt_reg_rdata;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      dm_req_ff <= '0;
      io_req_ff <= '0;
      pm_rd_ff <= 1'b0;
      pm_addr_ff <= 16'h0000;
      wdog_ff <= 1'b0;
    end
    else
    begin
      dm_req_ff <= nxt_dm_req;
      io_req_ff <= nxt_io_req;
      pm_rd_ff <= accept && is_prog;
      pm_addr_ff <= (accept && is_prog) ? ptr_val : pm_addr_ff;
      wdog_ff <= accept && (op == OP_WDOG_KICK);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pend_reg_ff <= 5'h00;
      pend_load_ff <= 1'b0;
      pend_io_ff <= 1'b0;
      pend_set_ff <= 1'b0;
      pend_bit_ff <= 3'h0;
    end
    else if (accept)
    begin
      pend_reg_ff <= cmd_in.reg_sel;
      pend_load_ff <= is_load;
      pend_io_ff <= data_is_io;
      pend_set_ff <= (op == OP_IO_SET);
      pend_bit_ff <= cmd_in.bit_sel;
    end
  end

  assign cmd_ready_out = ready_ff;
  assign dm_req_out = dm_req_ff;
  assign io_req_out = io_req_ff;
  assign pm_rd_out = pm_rd_ff;
  assign pm_addr_out = pm_addr_ff;
  assign wdog_kick_out = wdog_ff;
  assign dbg_halted_out = halted_ff;
  assign flags_out = flags_ff;
  assign reg_rdata_out = reg_rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [7:0] prev_val_ff, prev_flags_ff;
  logic [4:0] prev_reg_ff;
  logic [2:0] prev_bit_ff;
  logic [15:0] prev_ptr_ff;
  always_ff @(posedge mclk_in)
  begin
    prev_val_ff <= rd_val;
    prev_flags_ff <= flags_ff;
    prev_reg_ff <= cmd_in.reg_sel;
    prev_bit_ff <= cmd_in.bit_sel;
    prev_ptr_ff <= ptr_val;
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  AST_IO_SET: assert property (accept && op == OP_IO_SET |=> io_req_ff.rd_en ##1
    io_req_ff.wr_en && io_req_ff.wdata == ($past(io_rdata_in) | bit_mask(pend_bit_ff))
    && $stable(flags_ff)) else $error("io bit set wrong");
  AST_IO_CLR: assert property (accept && op == OP_IO_CLR |=> ##1
    io_req_ff.wr_en && !io_req_ff.wdata[pend_bit_ff] && ready_ff) else $error("io bit clear wrong");
  AST_IO_RANGE: assert property (state_ff == S_IO_RD |-> io_req_ff.addr <= IO_BIT_LAST)
    else $error("io bit op outside low window");
  AST_SHIFT_LEFT: assert property (accept && op == OP_SHIFT_LEFT |=>
    wreg_ff[prev_reg_ff] == {prev_val_ff[6:0], 1'b0} && flags_ff[FLAG_C] == prev_val_ff[7])
    else $error("shift left result wrong");
  AST_ROT_RIGHT: assert property (accept && op == OP_ROT_RIGHT |=>
    wreg_ff[prev_reg_ff] == {prev_flags_ff[FLAG_C], prev_val_ff[7:1]}
    && flags_ff[FLAG_C] == prev_val_ff[0]) else $error("rotate right wrong");
  AST_SIGNED: assert property (accept && op == OP_SHIFT_SIGNED |=>
    wreg_ff[prev_reg_ff] == {prev_val_ff[7], prev_val_ff[7:1]} && flags_ff[FLAG_C] == prev_val_ff[0]
    && flags_ff[FLAG_V] == (flags_ff[FLAG_N] ^ flags_ff[FLAG_C])) else $error("signed shift wrong");
  AST_SWAP: assert property (accept && op == OP_NIBBLE_SWAP |=>
    wreg_ff[prev_reg_ff] == {prev_val_ff[3:0], prev_val_ff[7:4]} && flags_ff == prev_flags_ff)
    else $error("nibble swap wrong");
  AST_FLAG_HIGH: assert property (accept && op == OP_FLAG_HIGH |=>
    flags_ff == (prev_flags_ff | bit_mask(prev_bit_ff))) else $error("flag set touched others");
  AST_LOAD_INC: assert property (accept && op == OP_LOAD_INC |=>
    (dm_req_ff.rd_en || io_req_ff.rd_en) && !ready_ff ##1 ready_ff) else $error("load timing");
  AST_IO_MAP: assert property (dm_req_ff.rd_en || dm_req_ff.wr_en |->
    dm_req_ff.addr < IO_DATA_OFFSET || dm_req_ff.addr >= IO_DATA_END) else $error("i/o leak");
  AST_PROG_3: assert property (accept && is_prog |=> pm_rd_ff && pm_addr_ff == prev_ptr_ff
    && !ready_ff ##1 !ready_ff ##1 ready_ff) else $error("program read timing");
  AST_WDOG: assert property (accept && op == OP_WDOG_KICK |=> wdog_ff && ready_ff
    && flags_ff == prev_flags_ff) else $error("watchdog kick wrong");

  COV_IO_SET: cover property (accept && op == OP_IO_SET ##2 accept);
  COV_PUSH_POP: cover property (accept && op == OP_PUSH ##2 accept && op == OP_POP);
  COV_PROG: cover property (accept && op == OP_PROG_READ_INC ##3 accept);
  COV_HALT: cover property (halted_ff ##1 !halted_ff);

endmodule
`default_nettype wire

/* File: verif/cbt_mem_model.sv */
// memory model: data memory, i/o space and program memory around the core
// assumes data and i/o reads answer in the strobe cycle, program reads one later
`timescale 1ns/10ps
`default_nettype none
module cbt_mem_model
  import cbt_pkg::*;
(
  // clock
  input wire logic mclk_in,
  // data and i/o space
  input wire cbt_mem_req_type dm_req_in,
  output logic [7:0] dm_rdata_out,
  input wire cbt_io_req_type io_req_in,
  output logic [7:0] io_rdata_out,
  // program memory
  input wire logic pm_rd_in,
  input wire logic [15:0] pm_addr_in,
  output logic [7:0] pm_rdata_out
);
  logic [7:0] dmem [256];
  logic [7:0] iomem [64];
  // idle read lines carry the inverted address, so a late sample looks right only where the byte equals that inverse
  assign dm_rdata_out = dm_req_in.rd_en ? dmem[dm_req_in.addr[7:0]] : ~dm_req_in.addr[7:0];
  assign io_rdata_out = io_req_in.rd_en ? iomem[io_req_in.addr] : ~{2'b00, io_req_in.addr};
  initial
  begin
    pm_rdata_out = 8'h00;
    for (int i = 0; i < 256; i++)
      dmem[i] = 8'(i) ^ 8'h5A;
    for (int i = 0; i < 64; i++)
      iomem[i] = 8'(i) ^ 8'hC3;
  end
  always @(posedge mclk_in)
  begin
    if (dm_req_in.wr_en)
      dmem[dm_req_in.addr[7:0]] <= dm_req_in.wdata;
    if (io_req_in.wr_en)
      iomem[io_req_in.addr] <= io_req_in.wdata;
    // program byte is a fixed function of its address
    pm_rdata_out <= pm_rd_in ? pm_addr_in[7:0] ^ pm_addr_in[15:8] ^ 8'h3C : ~pm_rdata_out;
  end
endmodule
`default_nettype wire

/* File: verif/cpu_bit_and_transfer_ops_tb.sv */
// self-checking bench of the bit, transfer and core-control executor
// assumes cbt_core and cbt_mem_model; registers reached over the register port
`timescale 1ns/10ps
`default_nettype none
module cpu_bit_and_transfer_ops_tb
  import cbt_pkg::*;
;
  logic mclk_in = 0, rst_n_in = 0, cmd_valid_in = 0, dbg_resume_in = 0;
  logic reg_wr_in = 0, reg_rd_in = 0, cmd_ready_out, pm_rd_out, wdog_kick_out, dbg_halted_out;
  cbt_cmd_type cmd_in = '0;
  cbt_mem_req_type dm_req_out;
  cbt_io_req_type io_req_out;
  logic [5:0] reg_addr_in = '0;
  logic [7:0] reg_wdata_in = '0, dm_rdata_in, io_rdata_in, pm_rdata_in, flags_out, reg_rdata_out;
  logic [15:0] pm_addr_out, last_addr = '0;
  logic [7:0] last_data = '0;
  int fail_count = 0, num_checks = 0, cyc = 0, kicks = 0, n = 0;
  cbt_core #(.SP_RESET(SP_RESET_DEFAULT)) cbt_core_i (.mclk_in, .rst_n_in, .cmd_valid_in,
    .cmd_in, .cmd_ready_out, .dm_req_out, .dm_rdata_in, .io_req_out, .io_rdata_in, .pm_rd_out,
    .pm_addr_out, .pm_rdata_in, .wdog_kick_out, .dbg_halted_out, .dbg_resume_in, .flags_out,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out);
  cbt_mem_model cbt_mem_model_i (.mclk_in, .dm_req_in(dm_req_out), .dm_rdata_out(dm_rdata_in),
    .io_req_in(io_req_out), .io_rdata_out(io_rdata_in), .pm_rd_in(pm_rd_out),
    .pm_addr_in(pm_addr_out), .pm_rdata_out(pm_rdata_in));
  always #12.5 mclk_in = ~mclk_in;
  ////////////////////////////////////////////////////////////////
  // i/o accesses are logged by their data-space address
  always @(posedge mclk_in)
  begin
    if (dm_req_out.rd_en | dm_req_out.wr_en)
      {last_addr, last_data} <= {dm_req_out.addr, dm_req_out.wdata};
    if (io_req_out.rd_en | io_req_out.wr_en)
      {last_addr, last_data} <= {{10'h000, io_req_out.addr} + IO_DATA_OFFSET, io_req_out.wdata};
    if (wdog_kick_out === 1'b1)
      kicks <= kicks + 1;
    cyc <= cyc + 1;
    if (cyc > 20000)
    begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic rw(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk_in);
    {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} <= {wr, ~wr, a, d};
    @(posedge mclk_in);
    {reg_wr_in, reg_rd_in} <= 2'b00;
    #1 q = reg_rdata_out;
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    rw(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, exp});
  endtask
  // n counts cycles from the taking edge until ready returns
  task automatic op(input cbt_cmd_type c);
    @(posedge mclk_in);
    {cmd_valid_in, cmd_in} <= {1'b1, c};
    do @(posedge mclk_in); while (cmd_ready_out !== 1'b1);
    cmd_valid_in <= 1'b0;
    #1 n = 1;
    while (cmd_ready_out !== 1'b1 && n < 100)
    begin
      @(posedge mclk_in);
      #1 n++;
    end
    @(posedge mclk_in);
    #1;
  endtask
  function automatic logic [15:0] exp_alu(cbt_op_type o, logic [7:0] v, logic [7:0] f, logic [2:0] b);
    logic [7:0] r;
    logic c;
    {r, c} = {v, f[FLAG_C]};
    case (o)
      OP_SHIFT_LEFT: {c, r} = {v, 1'b0};
      OP_SHIFT_RIGHT: {r, c} = {1'b0, v};
      OP_ROT_LEFT: {c, r} = {v, f[FLAG_C]};
      OP_ROT_RIGHT: {r, c} = {f[FLAG_C], v};
      OP_SHIFT_SIGNED: {r, c} = {v[7], v};
      OP_NIBBLE_SWAP: r = {v[3:0], v[7:4]};
      OP_FLAG_HIGH: f[b] = 1'b1;
      OP_FLAG_LOW: f[b] = 1'b0;
      OP_BIT_TO_T: f[FLAG_T] = v[b];
      OP_T_TO_BIT: r[b] = f[FLAG_T];
      default: ;
    endcase
    if (o inside {OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT, OP_SHIFT_SIGNED})
      f[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
    return {f, r};
  endfunction
  ////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] v, q;
    logic [5:0] pa;
    logic [15:0] p, np, ea, fl;
    cbt_cmd_type c;
    cbt_op_type ro[10] = '{OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT,
      OP_SHIFT_SIGNED, OP_NIBBLE_SWAP, OP_FLAG_HIGH, OP_FLAG_LOW, OP_BIT_TO_T, OP_T_TO_BIT};
    cbt_op_type mo[10] = '{OP_LOAD, OP_LOAD_INC, OP_LOAD_DEC, OP_LOAD_OFS, OP_STORE,
      OP_STORE_INC, OP_STORE_DEC, OP_STORE_OFS, OP_LOAD_DIRECT, OP_STORE_DIRECT};
    v = 8'($urandom(32'h0000_124f));
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rc(BUS_FLAGS_ADDR, FLAGS_RESET);
    rc(BUS_SP_LO_ADDR, SP_RESET_DEFAULT[7:0]);
    rw(1'b1, 6'h3F, 8'hFF, q);
    rc(6'h3F, 8'h00);
    for (int i = 0; i < 80; i++)
    begin
      c = '0;
      {c.op, c.reg_sel, c.bit_sel} = {ro[i % 10], 5'($urandom % 26), 3'(i / 10)};
      v = (i < 10) ? 8'h80 : (i < 20) ? 8'h01 : 8'($urandom);
      fl = 16'($urandom);
      rw(1'b1, {1'b0, c.reg_sel}, v, q);
      rw(1'b1, BUS_FLAGS_ADDR, fl[7:0], q);
      p = exp_alu(c.op, v, fl[7:0], c.bit_sel);
      op(c);
      chk(16'(n), 16'h0001);
      chk({8'h00, flags_out}, {8'h00, p[15:8]});
      rc({1'b0, c.reg_sel}, p[7:0]);
    end
    for (int i = 0; i < 60; i++)
    begin
      p = (i < 10) ? 16'hFFFF : (i < 20) ? 16'h0000 : (i < 40) ? 16'h0020 + 16'($urandom % 64) : 16'($urandom);
      c = '0;
      {c.op, c.ptr, c.reg_sel} = {mo[i % 10], cbt_ptr_type'(i % 3), 5'($urandom % 26)};
      {c.disp, c.addr, v} = {6'($urandom), p, 8'($urandom)};
      pa = {1'b0, PTR_X_LO} + 6'(2 * (i % 3));
      rw(1'b1, pa, p[7:0], q);
      rw(1'b1, pa + 6'h01, p[15:8], q);
      rw(1'b1, {1'b0, c.reg_sel}, v, q);
      np = p + 16'(c.op inside {OP_LOAD_INC, OP_STORE_INC}) - 16'(c.op inside {OP_LOAD_DEC, OP_STORE_DEC});
      ea = (c.op inside {OP_LOAD_OFS, OP_STORE_OFS}) ? p + {10'h000, c.disp}
        : (c.op inside {OP_LOAD_DEC, OP_STORE_DEC}) ? np : p;
      q = (ea >= IO_DATA_OFFSET && ea < IO_DATA_END) ? cbt_mem_model_i.iomem[ea[5:0] - 6'h20]
        : cbt_mem_model_i.dmem[ea[7:0]];
      fl = {8'h00, flags_out};
      op(c);
      chk(16'(n), 16'h0002);
      chk(last_addr, ea);
      if (c.op inside {OP_STORE, OP_STORE_INC, OP_STORE_DEC, OP_STORE_OFS, OP_STORE_DIRECT})
        chk({8'h00, last_data}, {8'h00, v});
      else
        rc({1'b0, c.reg_sel}, q);
      chk({8'h00, flags_out}, fl);
      rc(pa, np[7:0]);
      rc(pa + 6'h01, np[15:8]);
    end
    for (int i = 0; i < 16; i++)
    begin
      c = '0;
      c.op = (i % 2) ? OP_IO_CLR : OP_IO_SET;
      {c.io_addr, c.bit_sel} = {(i < 2) ? 5'h1F : 5'($urandom), 3'($urandom)};
      v = cbt_mem_model_i.iomem[{1'b0, c.io_addr}];
      v = (i % 2) ? v & ~(8'h01 << c.bit_sel) : v | (8'h01 << c.bit_sel);
      fl = {8'h00, flags_out};
      op(c);
      chk(16'(n), 16'h0002);
      chk(last_addr, {11'h000, c.io_addr} + IO_DATA_OFFSET);
      chk({last_data, flags_out}, {v, fl[7:0]});
    end
    for (int i = 0; i < 4; i++)
    begin
      p = (i == 3) ? 16'hFFFF : 16'($urandom);
      c = '0;
      c.op = (i % 2) ? OP_PROG_READ_INC : OP_PROG_READ;
      c.reg_sel = (i == 0) ? 5'h00 : 5'($urandom % 26);
      rw(1'b1, {1'b0, PTR_Z_LO}, p[7:0], q);
      rw(1'b1, {1'b0, PTR_Z_LO} + 6'h01, p[15:8], q);
      op(c);
      chk(16'(n), 16'h0003);
      chk(pm_addr_out, p);
      rc({1'b0, c.reg_sel}, p[7:0] ^ p[15:8] ^ 8'h3C);
      p = p + 16'(i % 2);
      rc({1'b0, PTR_Z_LO} + 6'h01, p[15:8]);
    end
    v = 8'($urandom);
    rw(1'b1, 6'h03, v, q);
    rw(1'b1, 6'h04, ~v, q);
    for (int i = 0; i < 4; i++)
    begin
      c = '0;
      {c.op, c.reg_sel} = {(i < 2) ? OP_PUSH : OP_POP, 5'(3 + i)};
      op(c);
      chk(16'(n), 16'h0002);
      chk(last_addr, (i == 0 || i == 3) ? 16'h00FF : 16'h00FE);
    end
    rc(6'h05, ~v);
    rc(6'h06, v);
    fl = 16'(kicks);
    c = '0;
    c.op = OP_WDOG_KICK;
    op(c);
    chk({16'(n), 16'(kicks)}, {16'h0001, fl + 16'h0001});
    c.op = OP_DEBUG_HALT;
    fork
      op(c);
      begin
        repeat (12) @(posedge mclk_in);
        chk(16'(dbg_halted_out), 16'h0001);
        dbg_resume_in <= 1'b1;
      end
    join
    dbg_resume_in <= 1'b0;
    chk(16'(n > 8), 16'h0001);
    final_report();
  end
endmodule
`default_nettype wire
